/* File: verilog/eatb_regs.vh */
// Purpose: Register map, field positions and reset values of the ports.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses.
`ifndef EATB_REGS_VH
`define EATB_REGS_VH

// ==========================================================
// Register offsets
// ==========================================================
`define EATB_ADDR_W          5
`define EATB_OFF_WIDE_PIN    5'h00
`define EATB_OFF_WIDE_LAT    5'h04
`define EATB_OFF_WIDE_DIR    5'h08
`define EATB_OFF_SMALL_PIN   5'h0C
`define EATB_OFF_SMALL_LAT   5'h10
`define EATB_OFF_SMALL_DIR   5'h14
`define EATB_OFF_ANALOG_SEL  5'h18
`define EATB_OFF_PAR_CTRL    5'h1C

// ==========================================================
// Field positions
// ==========================================================
`define EATB_DIR_WIDE_PU     7
`define EATB_DIR_SMALL_PU    6
`define EATB_PAR_ENABLE      0
`define EATB_PAR_MASTER      1
`define EATB_PAR_BYTE_EN     2

// ==========================================================
// Reset values
// ==========================================================
`define EATB_RST_WIDE_LAT    8'h00
`define EATB_RST_WIDE_DIR    8'hFF
`define EATB_RST_SMALL_LAT   3'h0
`define EATB_RST_SMALL_DIR   3'h7
`define EATB_RST_PULLUP      1'h0
`define EATB_RST_ANALOG      3'h7
`define EATB_RST_PAR_CTRL    3'h0

`endif

/* File: verilog/eatb_io_ports.v */
// Purpose: Eight-bit and three-bit general-purpose I/O ports with APB
//          register access, weak pull-up control, analog selection and
//          parallel port pin sharing.
// Assumes: Pin inputs are synchronous to clk; APB master per AMBA.
// Notes:   Pin levels pass a two-flop stage before software sees them.
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "eatb_regs.vh"

module eatb_io_ports
#(
    parameter LARGE_PKG = 1  // One on the larger package variant.
)
(
    input  wire        clk,
    input  wire        rst,
    // APB slave.
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire [31:0] prdata,
    output wire        pslverr,
    // Eight-bit port pins.
    input  wire [7:0]  wide_pin_in,
    output wire [7:0]  wide_pin_out,
    output wire [7:0]  wide_pin_oe,
    output wire [7:0]  wide_pullup_on,
    // Three-bit port pins.
    input  wire [2:0]  small_pin_in,
    output wire [2:0]  small_pin_out,
    output wire [2:0]  small_pin_oe,
    output wire [2:0]  small_pullup_on,
    output wire [2:0]  analog_select,
    // Parallel port side.
    input  wire        par_read_strobe,
    input  wire        par_write_strobe,
    input  wire        par_byte_enable,
    input  wire [1:0]  par_data_out,
    input  wire        par_data_active,
    output wire        par_read_strobe_in,
    output wire        par_write_strobe_in,
    output wire [1:0]  par_data_in,
    // Remappable peripheral side for pins 23 and 24.
    input  wire [1:0]  remap_out,
    input  wire [1:0]  remap_active,
    output wire [1:0]  remap_in
);

    // ==========================================================
    // Constants and package gating
    // ==========================================================
    // The port logic exists only when the package carries the pins.
    localparam [0:0] IMPL = (LARGE_PKG != 0) ? 1'b1 : 1'b0;

    // ==========================================================
    // Register state
    // ==========================================================
    reg  [7:0]  wide_lat_ff;      // Eight-bit port output latch.
    reg  [7:0]  wide_dir_ff;      // Eight-bit port direction bits.
    reg  [2:0]  small_lat_ff;     // Three-bit port output latch.
    reg  [2:0]  small_dir_ff;     // Three-bit port direction bits.
    reg         wide_pu_ff;       // Eight-bit port group pull-up.
    reg         small_pu_ff;      // Three-bit port group pull-up.
    reg  [2:0]  analog_ff;        // Analog selection per pin.
    reg  [2:0]  par_ctrl_ff;      // Parallel port pin control.
    reg         pready_ff;        // APB ready.
    reg  [31:0] prdata_ff;        // APB read data.
    reg         pslverr_ff;       // APB error answer.
    reg  [7:0]  wide_meta_ff;     // First synchroniser stage.
    reg  [7:0]  wide_sync_ff;     // Second synchroniser stage.
    reg  [2:0]  small_meta_ff;    // First synchroniser stage.
    reg  [2:0]  small_sync_ff;    // Second synchroniser stage.
    reg  [7:0]  wide_out_ff;      // Registered pin output value.
    reg  [7:0]  wide_oe_ff;       // Registered pin output enable.
    reg  [7:0]  wide_pu_on_ff;    // Registered pull-up control.
    reg  [2:0]  small_out_ff;     // Registered pin output value.
    reg  [2:0]  small_oe_ff;      // Registered pin output enable.
    reg  [2:0]  small_pu_on_ff;   // Registered pull-up control.
    reg  [2:0]  analog_out_ff;    // Registered analog selection.
    reg         par_rd_in_ff;     // Incoming read strobe.
    reg         par_wr_in_ff;     // Incoming write strobe.
    reg  [1:0]  par_data_in_ff;   // Incoming parallel data.
    reg  [1:0]  remap_in_ff;      // Incoming remap pin levels.

    // ==========================================================
    // Bus decode
    // ==========================================================
    wire [`EATB_ADDR_W-1:0] addr_lo;   // Low address bits.
    wire        addr_hit;              // Address inside the map.
    wire        acc_phase;             // Access phase, not yet done.
    wire        wr_fire;               // Write takes effect now.
    reg  [31:0] nxt_prdata;            // Read data for this address.
    reg         nxt_hit;               // Offset is mapped.
    wire [2:0]  small_digital_in;      // Digital level, analog masked.

    assign addr_lo   = paddr[`EATB_ADDR_W-1:0];
    assign addr_hit  = (paddr[31:`EATB_ADDR_W] == 27'h0000000) & nxt_hit;
    assign acc_phase = psel & penable & ~pready_ff;
    // A write lands only at the edge where ready is sampled high.
    assign wr_fire   = psel & penable & pready_ff & pwrite & addr_hit;

    // Analog-selected pins have their digital input path cut.
    assign small_digital_in = small_sync_ff & ~analog_ff;

    // Read multiplexer; unimplemented bits read as zero.
    always @*
    begin
        nxt_prdata = 32'h00000000;
        nxt_hit    = 1'b1;
        case (addr_lo)
            `EATB_OFF_WIDE_PIN: nxt_prdata[7:0] = wide_sync_ff;
            `EATB_OFF_WIDE_LAT: nxt_prdata[7:0] = wide_lat_ff;
            `EATB_OFF_WIDE_DIR: nxt_prdata[7:0] = wide_dir_ff;
            `EATB_OFF_SMALL_PIN: nxt_prdata[2:0] = small_digital_in;
            // Latched value, never the pin level.
            `EATB_OFF_SMALL_LAT: nxt_prdata[2:0] = small_lat_ff;
            `EATB_OFF_SMALL_DIR:
            begin
                nxt_prdata[`EATB_DIR_WIDE_PU]  = wide_pu_ff;
                nxt_prdata[`EATB_DIR_SMALL_PU] = small_pu_ff;
                nxt_prdata[2:0] = small_dir_ff;
            end
            `EATB_OFF_ANALOG_SEL: nxt_prdata[2:0] = analog_ff;
            `EATB_OFF_PAR_CTRL: nxt_prdata[2:0] = par_ctrl_ff;
            default: nxt_hit = 1'b0;
        endcase
        // On the small package the whole map reads as zero.
        if (IMPL == 1'b0)
            nxt_prdata = 32'h00000000;
    end

    // ==========================================================
    // APB answer
    // ==========================================================
    // Ready rises one cycle into the access phase, with the read data
    // and error captured alongside, so every transfer takes two cycles
    // of access phase after setup.
    always @(posedge clk)
    begin
        if (rst | ~acc_phase)
        begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff  <= 1'b1;
            // Writes and unmapped reads answer with zero data.
            prdata_ff  <= (pwrite | ~addr_hit) ? 32'h00000000 : nxt_prdata;
            pslverr_ff <= ~addr_hit;
        end
    end

    // ==========================================================
    // Software registers
    // ==========================================================
    // Reset leaves the small port analog, inputs, with pull-ups off.
    always @(posedge clk)
    begin
        if (rst)
        begin
            wide_lat_ff  <= `EATB_RST_WIDE_LAT;
            wide_dir_ff  <= `EATB_RST_WIDE_DIR;
            small_lat_ff <= `EATB_RST_SMALL_LAT;
            small_dir_ff <= `EATB_RST_SMALL_DIR;
            wide_pu_ff   <= `EATB_RST_PULLUP;
            small_pu_ff  <= `EATB_RST_PULLUP;
            analog_ff    <= `EATB_RST_ANALOG;
            par_ctrl_ff  <= `EATB_RST_PAR_CTRL;
        end
        else if (wr_fire & IMPL)
        begin
            case (addr_lo)
                // A pin register write updates the latch.
                `EATB_OFF_WIDE_PIN, `EATB_OFF_WIDE_LAT:
                    wide_lat_ff <= pwdata[7:0];
                `EATB_OFF_WIDE_DIR: wide_dir_ff <= pwdata[7:0];
                `EATB_OFF_SMALL_PIN, `EATB_OFF_SMALL_LAT:
                    small_lat_ff <= pwdata[2:0];
                `EATB_OFF_SMALL_DIR:
                begin
                    wide_pu_ff   <= pwdata[`EATB_DIR_WIDE_PU];
                    small_pu_ff  <= pwdata[`EATB_DIR_SMALL_PU];
                    small_dir_ff <= pwdata[2:0];
                end
                `EATB_OFF_ANALOG_SEL: analog_ff <= pwdata[2:0];
                `EATB_OFF_PAR_CTRL: par_ctrl_ff <= pwdata[2:0];
                default: par_ctrl_ff <= par_ctrl_ff;
            endcase
        end
    end

    // ==========================================================
    // Pin input synchronisers
    // ==========================================================
    // The first stage is read only by the second.
    always @(posedge clk)
    begin
        if (rst)
        begin
            wide_meta_ff  <= 8'h00;
            wide_sync_ff  <= 8'h00;
            small_meta_ff <= 3'h0;
            small_sync_ff <= 3'h0;
        end
        else
        begin
            wide_meta_ff  <= wide_pin_in;
            wide_sync_ff  <= wide_meta_ff;
            small_meta_ff <= small_pin_in;
            small_sync_ff <= small_meta_ff;
        end
    end

    // ==========================================================
    // Eight-bit port pin drivers
    // ==========================================================
    // Pins 6 and 7 share with parallel data and remap pins; a remap
    // peripheral outranks parallel data, which outranks the latch.
    // The direction bit always sets the driver.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_wide
            wire nxt_val;  // Selected output value for this pin.
            if (gi >= 6)
            begin : g_shared
                assign nxt_val =
                    remap_active[gi-6] ? remap_out[gi-6] :
                    par_data_active    ? par_data_out[gi-6] :
                    wide_lat_ff[gi];
            end
            else
            begin : g_plain
                assign nxt_val = wide_lat_ff[gi];
            end
            always @(posedge clk)
            begin
                if (rst)
                begin
                    wide_out_ff[gi]   <= 1'b0;
                    wide_oe_ff[gi]    <= 1'b0;
                    wide_pu_on_ff[gi] <= 1'b0;
                end
                else
                begin
                    wide_out_ff[gi] <= nxt_val & IMPL;
                    // Direction zero drives, one floats.
                    wide_oe_ff[gi] <= ~wide_dir_ff[gi] & IMPL;
                    // Pull-up only for a pin that is an input.
                    wide_pu_on_ff[gi] <= wide_pu_ff &
                                         wide_dir_ff[gi] & IMPL;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Three-bit port pin drivers
    // ==========================================================
    // Each pin drives its latch or its parallel strobe; the analog
    // selection plays no part in the output path.
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_small
            wire par_drv;  // Parallel function owns this pin.
            wire par_val;  // Parallel strobe value for this pin.
            if (gi == 0)
            begin : g_rd
                // Read strobe is an output only in master use.
                assign par_drv = par_ctrl_ff[`EATB_PAR_ENABLE] &
                                 par_ctrl_ff[`EATB_PAR_MASTER];
                assign par_val = par_read_strobe;
            end
            else if (gi == 1)
            begin : g_wr
                assign par_drv = par_ctrl_ff[`EATB_PAR_ENABLE];
                assign par_val = par_write_strobe;
            end
            else
            begin : g_cs
                assign par_drv = par_ctrl_ff[`EATB_PAR_ENABLE] &
                                 par_ctrl_ff[`EATB_PAR_BYTE_EN];
                assign par_val = par_byte_enable;
            end
            always @(posedge clk)
            begin
                if (rst)
                begin
                    small_out_ff[gi]   <= 1'b0;
                    small_oe_ff[gi]    <= 1'b0;
                    small_pu_on_ff[gi] <= 1'b0;
                end
                else
                begin
                    small_out_ff[gi] <= (par_drv ? par_val :
                                         small_lat_ff[gi]) & IMPL;
                    // Direction rules the driver, analog or not.
                    small_oe_ff[gi] <= ~small_dir_ff[gi] &
                                       IMPL;
                    small_pu_on_ff[gi] <= small_pu_ff & small_dir_ff[gi] &
                                          IMPL;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Peripheral input paths
    // ==========================================================
    // Incoming strobes use the digital path, so analog pins read zero.
    always @(posedge clk)
    begin
        if (rst)
        begin
            analog_out_ff  <= `EATB_RST_ANALOG;
            par_rd_in_ff   <= 1'b0;
            par_wr_in_ff   <= 1'b0;
            par_data_in_ff <= 2'h0;
            remap_in_ff    <= 2'h0;
        end
        else
        begin
            analog_out_ff  <= analog_ff & {3{IMPL}};
            par_rd_in_ff   <= small_digital_in[0] & IMPL;
            par_wr_in_ff   <= small_digital_in[1] & IMPL;
            par_data_in_ff <= wide_sync_ff[7:6] & {2{IMPL}};
            remap_in_ff    <= wide_sync_ff[7:6] & {2{IMPL}};
        end
    end

    // ==========================================================
    // Output wiring
    // ==========================================================
    assign pready              = pready_ff;
    assign prdata              = prdata_ff;
    assign pslverr             = pslverr_ff;
    assign wide_pin_out        = wide_out_ff;
    assign wide_pin_oe         = wide_oe_ff;
    assign wide_pullup_on      = wide_pu_on_ff;
    assign small_pin_out       = small_out_ff;
    assign small_pin_oe        = small_oe_ff;
    assign small_pullup_on     = small_pu_on_ff;
    assign analog_select       = analog_out_ff;
    assign par_read_strobe_in  = par_rd_in_ff;
    assign par_write_strobe_in = par_wr_in_ff;
    assign par_data_in         = par_data_in_ff;
    assign remap_in            = remap_in_ff;

endmodule // eatb_io_ports

/* File: dv/eatb_board.sv */
// Purpose: Board model that settles the level seen on each port pin.
// Assumes: An enabled output driver wins over the board and the pull-up.
// Notes:   A pin nobody drives and no pull-up holds toggles every cycle.
`timescale 1ns/1ps
module eatb_board
#(
    parameter W = 8
)
(
    input  wire          clk,
    input  wire  [W-1:0] pin_out,
    input  wire  [W-1:0] pin_oe,
    input  wire  [W-1:0] pull_on,
    input  wire  [W-1:0] ext_en,
    input  wire  [W-1:0] ext_val,
    output logic [W-1:0] pin_in
);
    // Alternating level stands in for a floating pin.
    logic [W-1:0] float_ff = '0;

    always @(posedge clk)
    begin
        float_ff <= ~float_ff;
    end

    // Own driver first, then the board, then the weak pull-up.
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pull_on[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = float_ff[i];
        end
    end
endmodule // eatb_board

/* File: dv/eatb_io_ports_monitor.sv */
// Purpose: Port-level assertions for the two I/O ports.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Pipeline checks wait until the pipeline holds post-reset data.
`timescale 1ns/1ps
module eatb_io_ports_monitor
(
    input wire        clk,
    input wire        rst,
    input wire        psel,
    input wire        penable,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    input wire [7:0]  wide_pin_in,
    input wire [7:0]  wide_pin_oe,
    input wire [7:0]  wide_pullup_on,
    input wire [2:0]  small_pin_in,
    input wire [2:0]  small_pin_oe,
    input wire [2:0]  small_pullup_on,
    input wire [2:0]  analog_select,
    input wire        par_read_strobe_in,
    input wire        par_write_strobe_in,
    input wire [1:0]  par_data_in,
    input wire [1:0]  remap_in
);
    // Edges since reset, saturating, so $past never looks into reset.
    logic [2:0] up_ff;

    always @(posedge clk)
    begin
        if (rst)
            up_ff <= 3'h0;
        else if (up_ff != 3'h7)
            up_ff <= up_ff + 3'h1;
    end

    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (rst);

    a_small_pu_off:
        assert property ((small_pullup_on & small_pin_oe) == 3'h0)
        else $error("small pull-up on an output pin");
    a_wide_pu_off:
        assert property ((wide_pullup_on & wide_pin_oe) == 8'h00)
        else $error("wide pull-up on an output pin");
    a_reset_state:
        assert property ($fell(rst) |-> analog_select == 3'h7 &&
            small_pullup_on == 3'h0 && wide_pullup_on == 8'h00 &&
            small_pin_oe == 3'h0)
        else $error("state after reset wrong");
    a_ready_next:
        assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    a_err_ready:
        assert property (pslverr |-> pready && $past(psel && penable))
        else $error("error without transfer");
    a_idle_rdata:
        assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_par_data_sync:
        assert property (up_ff == 3'h7 |->
            par_data_in == $past(wide_pin_in[7:6], 3))
        else $error("parallel data input path wrong");
    a_remap_sync:
        assert property (up_ff == 3'h7 |->
            remap_in == $past(wide_pin_in[7:6], 3))
        else $error("remap input path wrong");
    a_analog_rd_zero:
        assert property (analog_select[0] [*4] |-> !par_read_strobe_in)
        else $error("analog pin seen as digital");
    a_wr_strobe_sync:
        assert property ((!analog_select[1]) [*4] ##0 up_ff == 3'h7 |->
            par_write_strobe_in == $past(small_pin_in[1], 3))
        else $error("write strobe input path wrong");
endmodule // eatb_io_ports_monitor

bind eatb_io_ports eatb_io_ports_monitor u_mon
(
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .wide_pin_in(wide_pin_in), .wide_pin_oe(wide_pin_oe),
    .wide_pullup_on(wide_pullup_on), .small_pin_in(small_pin_in),
    .small_pin_oe(small_pin_oe), .small_pullup_on(small_pullup_on),
    .analog_select(analog_select),
    .par_read_strobe_in(par_read_strobe_in),
    .par_write_strobe_in(par_write_strobe_in),
    .par_data_in(par_data_in), .remap_in(remap_in)
);

/* File: dv/eatb_io_ports_bench.sv */
// Purpose: Self-checking bench for the two I/O ports.
// Assumes: APB answers are compared in order by a watcher process.
// Notes:   Board model settles the pin levels fed back to the ports.
`timescale 1ns/1ps
`include "eatb_regs.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
    $display("ERROR %0t got %h want %h", $time, a, e); end end
module eatb_io_ports_bench;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr;
    logic [31:0] paddr = '0, pwdata = '0, prdata, r;
    logic [7:0]  wide_pin_in, wide_pin_out, wide_pin_oe, wide_pullup_on;
    logic [7:0]  wide_ext_en = '0, wide_ext_val = '0;
    logic [2:0]  small_pin_in, small_pin_out, small_pin_oe, small_pu_on;
    logic [2:0]  small_ext_en = '0, small_ext_val = '0, analog_select;
    logic [2:0]  strobes = '0;
    logic [1:0]  par_data_out = '0, remap_out = '0, remap_active = '0;
    logic [1:0]  par_data_in, remap_in;
    logic        par_data_active = 1'b0, rd_in, wr_in;
    logic [32:0] expq[$], want;
    int          tests_run = 0, fails = 0, seed = 90178;

    always #20 clk = ~clk;

    eatb_io_ports dut
    (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .wide_pin_in(wide_pin_in),
        .wide_pin_out(wide_pin_out), .wide_pin_oe(wide_pin_oe),
        .wide_pullup_on(wide_pullup_on), .small_pin_in(small_pin_in),
        .small_pin_out(small_pin_out), .small_pin_oe(small_pin_oe),
        .small_pullup_on(small_pu_on), .analog_select(analog_select),
        .par_read_strobe(strobes[0]), .par_write_strobe(strobes[1]),
        .par_byte_enable(strobes[2]), .par_data_out(par_data_out),
        .par_data_active(par_data_active), .par_read_strobe_in(rd_in),
        .par_write_strobe_in(wr_in), .par_data_in(par_data_in),
        .remap_out(remap_out), .remap_active(remap_active),
        .remap_in(remap_in)
    );
    eatb_board #(.W(8)) u_wide
    (
        .clk(clk), .pin_out(wide_pin_out), .pin_oe(wide_pin_oe),
        .pull_on(wide_pullup_on), .ext_en(wide_ext_en),
        .ext_val(wide_ext_val), .pin_in(wide_pin_in)
    );
    eatb_board #(.W(3)) u_small
    (
        .clk(clk), .pin_out(small_pin_out), .pin_oe(small_pin_oe),
        .pull_on(small_pu_on), .ext_en(small_ext_en),
        .ext_val(small_ext_val), .pin_in(small_pin_in)
    );

    // One APB transfer; the expected answer is queued at setup.
    task automatic apb(input logic w, input logic [31:0] a, d, e,
                       input logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        expq.push_back({err, w ? 32'h0 : e});
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [31:0] a, e);
        apb(1'b0, a, 32'h0, e, 1'b0);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Oldest queued answer is compared whenever the slave answers.
    always @(posedge clk)
    begin
        if (pready === 1'b1)
        begin
            want = expq.pop_front();
            `CHK({pslverr, prdata}, want)
        end
    end

    task test_done;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog for a hung handshake.
    initial
    begin
        #800000;
        fails++;
        test_done;
    end

    initial
    begin
        r = $random(seed);
        tick(4);
        rst <= 1'b0;
        rd(`EATB_OFF_WIDE_LAT, 32'h0);
        rd(`EATB_OFF_WIDE_DIR, 32'hFF);
        rd(`EATB_OFF_SMALL_DIR, 32'h7);
        rd(`EATB_OFF_ANALOG_SEL, 32'h7);
        rd(`EATB_OFF_SMALL_PIN, 32'h0);
        apb(1'b0, 32'h20, 32'h0, 32'h0, 1'b1);
        `CHK(small_pin_oe, 3'h0)
        // Digital inputs, mixed directions, pull-up on a floating pin.
        small_ext_val <= r[2:0];
        small_ext_en <= 3'h7;
        wr(`EATB_OFF_ANALOG_SEL, 32'h0);
        rd(`EATB_OFF_SMALL_PIN, {29'h0, r[2:0]});
        wr(`EATB_OFF_SMALL_LAT, {29'h0, r[5:3]});
        wr(`EATB_OFF_SMALL_DIR, 32'h42);
        small_ext_en <= 3'h0;
        tick(3);
        `CHK(small_pin_oe, 3'h5)
        `CHK(small_pin_out & 3'h5, r[5:3] & 3'h5)
        `CHK(small_pu_on, 3'h2)
        rd(`EATB_OFF_SMALL_LAT, {29'h0, r[5:3]});
        rd(`EATB_OFF_SMALL_PIN, {29'h0, r[5], 1'b1, r[3]});
        // Analog selection keeps outputs but reads zero.
        wr(`EATB_OFF_ANALOG_SEL, 32'h7);
        tick(2);
        `CHK(small_pin_out & 3'h5, r[5:3] & 3'h5)
        rd(`EATB_OFF_SMALL_PIN, 32'h0);
        wr(`EATB_OFF_ANALOG_SEL, 32'h0);
        // Pin-register writes land in the latch.
        wr(`EATB_OFF_SMALL_PIN, {29'h0, r[8:6]});
        rd(`EATB_OFF_SMALL_LAT, {29'h0, r[8:6]});
        wr(`EATB_OFF_WIDE_PIN, {24'h0, r[15:8]});
        rd(`EATB_OFF_WIDE_LAT, {24'h0, r[15:8]});
        // Wide port directions and group pull-up.
        wide_ext_val <= r[23:16];
        wide_ext_en <= 8'h03;
        wr(`EATB_OFF_WIDE_DIR, 32'h0F);
        wr(`EATB_OFF_SMALL_DIR, 32'h80);
        tick(3);
        `CHK(wide_pin_oe, 8'hF0)
        `CHK(wide_pullup_on, 8'h0F)
        `CHK(wide_pin_out[7:4], r[15:12])
        rd(`EATB_OFF_WIDE_PIN, {24'h0, r[15:12], 2'h3, r[17:16]});
        // Remap and parallel data on pins 6 and 7.
        remap_out <= r[25:24];
        par_data_out <= r[27:26];
        par_data_active <= 1'b1;
        remap_active <= 2'h1;
        tick(5);
        `CHK(wide_pin_out[7:6], {r[27], r[24]})
        `CHK(par_data_in, {r[27], r[24]})
        `CHK(remap_in, {r[27], r[24]})
        // Parallel strobes as outputs in master use.
        wr(`EATB_OFF_PAR_CTRL, 32'h7);
        for (int i = 0; i < 8; i++)
        begin
            strobes <= i[2:0];
            tick(2);
            `CHK(small_pin_out, i[2:0])
        end
        // Strobes as inputs in slave use.
        wr(`EATB_OFF_PAR_CTRL, 32'h1);
        wr(`EATB_OFF_SMALL_DIR, 32'h3);
        small_ext_en <= 3'h3;
        for (int j = 1; j < 3; j++)
        begin
            small_ext_val <= j[2:0];
            tick(5);
            `CHK(rd_in, j[0])
            `CHK(wr_in, j[1])
        end
        test_done;
    end
endmodule // eatb_io_ports_bench
